// File: stpdrv_ahb.sv
`timescale 1ns/1ps
// AHB-Lite slave: zero wait states, always OKAY
module stpdrv_ahb import stpdrv_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire stpdrv_stat_s stat,
  input  wire logic [13:0]  cur_word,
  output stpdrv_ctrl_s      ctrl
);

  typedef struct packed {
    stpdrv_ctrl_s ctrl;    // Switch image
    logic         wr_pnd;  // Control write waiting for its data phase
    logic [31:0]  rdata;   // Read data captured in the address phase
  } stpdrv_ahb_s;

  stpdrv_ahb_s st_r;
  stpdrv_ahb_s st_nxt;
  logic        req;

  assign req = hsel && htrans[1] && hready;

  // Decode the address phase, commit writes in the data phase
  always_comb begin
    st_nxt        = st_r;
    st_nxt.wr_pnd = 1'b0;
    if (st_r.wr_pnd) begin
      st_nxt.ctrl = stpdrv_ctrl_s'(hwdata[CTRL_W-1:0]);
    end
    if (req) begin
      st_nxt.rdata = 32'h0000_0000;  // Unmapped addresses read zero
      if (hwrite) begin
        // Only whole-word writes to the control word take effect
        st_nxt.wr_pnd = (haddr[3:0] == OFS_CTRL) && (haddr[31:4] == 28'h000_0000) && (hsize == HSIZE_WORD);
      end else if (haddr[31:4] == 28'h000_0000) begin
        case (haddr[3:0])
          OFS_CTRL:    st_nxt.rdata = {23'h00_0000, st_r.ctrl};
          OFS_STATUS:  st_nxt.rdata = {20'h0_0000, stat};
          OFS_CURRENT: st_nxt.rdata = {18'h0_0000, cur_word};
          default:     st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {stpdrv_ctrl_s'(CTRL_RST[CTRL_W-1:0]), 1'b0, 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata    = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ctrl      = st_r.ctrl;

endmodule // stpdrv_ahb

// File: stpdrv_indexer.sv
`timescale 1ns/1ps
// Step and direction source standing in for the external indexer
module stpdrv_indexer #(
  parameter int unsigned SETUP = 100,  // 2 us of direction setup at 50 MHz
  parameter int unsigned LOW   = 25    // 0.5 us, the shortest pulse the drive must take
) (
  input  wire logic clk,
  input  wire logic req,
  input  wire logic dir,
  output logic      step_o,
  output logic      dir_o,
  output logic      ack
);
  // Step line rests high, so only a falling edge can move the motor
  initial begin
    step_o = 1'b1;
    dir_o  = 1'b0;
    ack    = 1'b0;
  end

  // One pulse per request; direction moves well ahead of the falling edge
  always begin
    @(posedge clk iff req);
    dir_o <= dir;
    repeat (SETUP) @(posedge clk);
    step_o <= 1'b0;
    repeat (LOW) @(posedge clk);
    step_o <= 1'b1;
    ack    <= 1'b1;
    @(posedge clk);
    ack    <= 1'b0;
  end
endmodule // stpdrv_indexer

// File: stpdrv_pkg.sv
// Shared constants, types and decoders of the step drive control
package stpdrv_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS     = 20;             // 50 MHz core clock
  localparam int unsigned TEST_STEP_RATE_HZ = 100;            // Self-test half steps per second
  localparam int unsigned TEST_PERIOD_NS    = 1_000_000_000 / TEST_STEP_RATE_HZ;
  localparam int unsigned TEST_STEP_CYC     = TEST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_TIME_MS      = 1000;           // Rest time before current drops
  localparam int unsigned IDLE_CYC          = (IDLE_TIME_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W             = 26;             // Wide enough for both long counts

  // Phase table: 4 full steps per electrical cycle, 50 microsteps each
  localparam int unsigned IDX_W             = 8;
  localparam logic [7:0]  TABLE_LEN         = 8'hC8;          // 200 entries
  localparam logic [7:0]  IDX_RST           = 8'h00;          // Power-up table entry
  localparam logic [7:0]  INC_HALF          = 8'h19;          // 25 entries per half step
  localparam logic [7:0]  INC_FIFTH         = 8'h0A;
  localparam logic [7:0]  INC_TENTH         = 8'h05;
  localparam logic [7:0]  INC_FIFTIETH      = 8'h01;
  localparam logic [7:0]  HALF_REV_STEPS    = 8'hC8;          // 200 half steps on a 1.8 degree motor

  // Current in units of 0.1 A, output in units of 0.05 A
  localparam logic [5:0]  BASE_CUR          = 6'h04;          // Always-present 0.4 A
  localparam logic [6:0]  CUR_OFF           = 7'h00;

  // Register byte offsets
  localparam logic [3:0]  OFS_CTRL          = 4'h0;
  localparam logic [3:0]  OFS_STATUS        = 4'h4;
  localparam logic [3:0]  OFS_CURRENT       = 4'h8;
  localparam logic [2:0]  HSIZE_WORD        = 3'h2;
  localparam logic [31:0] CTRL_RST          = 32'h0000_0000;  // Test off, half step, no idle cut, 0.4 A
  localparam int unsigned CTRL_W            = 9;
  localparam int unsigned STAT_W            = 12;
  localparam int unsigned CURSET_POS        = 0;
  localparam int unsigned CUROUT_POS        = 8;

  // Step resolution selected by the two resolution switches
  typedef enum logic [1:0] {
    RES_HALF     = 2'b00,
    RES_FIFTH    = 2'b01,
    RES_TENTH    = 2'b10,
    RES_FIFTIETH = 2'b11
  } stpdrv_res_e;

  // Self-test motion phases
  typedef enum logic [1:0] {
    TST_OFF = 2'b00,
    TST_FWD = 2'b01,
    TST_REV = 2'b10
  } stpdrv_tst_e;

  // Switch image held in the control register
  typedef struct packed {
    logic [4:0]  cur;   // Current weights 1.6/0.8/0.4/0.2/0.1 A
    logic        idle;  // Idle reduction switch
    stpdrv_res_e res;   // Resolution switches
    logic        test;  // Self-test switch
  } stpdrv_ctrl_s;

  // Live state shown to software
  typedef struct packed {
    logic       dir;       // Last direction moved
    logic       test_run;  // Self-test motion active
    logic       idle_red;  // Idle reduction in force
    logic       amp_on;    // Phase current on
    logic [7:0] idx;       // Phase table index
  } stpdrv_stat_s;

  // Table advance per step for each resolution
  function automatic logic [7:0] res_inc(input stpdrv_res_e res);
    case (res)
      RES_HALF:     res_inc = INC_HALF;
      RES_FIFTH:    res_inc = INC_FIFTH;
      RES_TENTH:    res_inc = INC_TENTH;
      default:      res_inc = INC_FIFTIETH;
    endcase
  endfunction

  // Move the index by inc, wrapping at both ends of the table
  function automatic logic [7:0] idx_step(input logic [7:0] idx, input logic [7:0] inc, input logic up);
    logic [8:0] sum;
    sum = 9'h000;
    if (up) begin
      sum = {1'b0, idx} + {1'b0, inc};
      if (sum >= {1'b0, TABLE_LEN}) begin
        sum = sum - {1'b0, TABLE_LEN};
      end
    end else begin
      sum = (idx >= inc) ? ({1'b0, idx} - {1'b0, inc}) : ({1'b0, idx} + {1'b0, TABLE_LEN} - {1'b0, inc});
    end
    idx_step = sum[7:0];
  endfunction

  // Setpoint in 0.1 A units from the current switches
  function automatic logic [5:0] cur_set(input logic [4:0] sw);
    cur_set = BASE_CUR + {1'b0, sw};
  endfunction

endpackage

// File: stpdrv_tb.sv
`timescale 1ns/1ps
// Register-level bench of the step drive control
module testbench import stpdrv_pkg::*; ;
  localparam int unsigned TC = 4;    // Short self-test step period
  localparam int unsigned IT = 200;  // Short idle wait, longer than one pulse
  logic        MCLK, NRST, HSEL, HWRITE, EN_IN, req, dir, ack;
  logic        STEP_IN, DIR_IN, HREADYOUT, HRESP, AMP_ON;
  logic [31:0] HADDR, HWDATA, HRDATA, r;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [7:0]  PHASE_IDX, exp_idx, p;
  logic [6:0]  PHASE_CUR;
  logic [4:0]  sws [6];              // Current switch patterns to try
  stpdrv_ctrl_s c;                   // Switch image written to the control word
  wire         HREADY = HREADYOUT;   // Single slave drives the bus ready
  int          n_mismatch, total_checks, k;

  stpdrv_top #(.TEST_CYC(TC), .IDLE_WAIT(IT)) dut (
    .MCLK(MCLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN), .EN_IN(EN_IN), .PHASE_IDX(PHASE_IDX),
    .PHASE_CUR(PHASE_CUR), .AMP_ON(AMP_ON));
  stpdrv_indexer ixr (.clk(MCLK), .req(req), .dir(dir), .step_o(STEP_IN), .dir_o(DIR_IN), .ack(ack));

  // Free-running core clock
  initial begin
    MCLK = 1'b0;
    forever #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;
  end

  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare one seen value with its expectation
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask

  // A wait that ran out ends the run
  task hang(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
    end_sim;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // Wait for bus ready, bounded
  task rdy;
    int i;
    i = 0;
    do begin
      @(posedge MCLK);
      i++;
    end while (HREADYOUT !== 1'b1 && i < 50);
    if (HREADYOUT !== 1'b1) hang("no bus ready");
  endtask

  // One single AHB-Lite word transfer; read data taken at the end of the data phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    HSEL   <= 1'b1;
    HADDR  <= a;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HSIZE  <= HSIZE_WORD;
    rdy;
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rdy;
    q = HRDATA;
    chk(32'(HRESP), 32'h0000_0000, "bus response");
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task rd(input logic [31:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0000_0000, q);
  endtask

  // Ask the indexer for one pulse and track where the index should land
  task stp(input logic d, input logic [7:0] inc, input logic track);
    int i;
    req <= 1'b1;
    dir <= d;
    i = 0;
    do begin
      @(posedge MCLK);
      i++;
    end while (ack !== 1'b1 && i < 400);
    req <= 1'b0;
    if (ack !== 1'b1) hang("no step done");
    if (track) begin
      i = int'(exp_idx) + (d ? int'(inc) : int'(TABLE_LEN) - int'(inc));
      exp_idx = 8'(i % int'(TABLE_LEN));
    end
  endtask

  // Watch self-test motion: size, direction and spacing of the first 400 moves
  task mon;
    int n, g, d;
    logic [7:0] q;
    n = 0;
    g = 0;
    q = PHASE_IDX;
    repeat (400 * TC + 10) begin
      @(posedge MCLK);
      g++;
      if (PHASE_IDX !== q) begin
        d = (int'(PHASE_IDX) + int'(TABLE_LEN) - int'(q)) % int'(TABLE_LEN);
        if (n < 400) chk(32'(d), (n < 200) ? 32'h0000_0019 : 32'h0000_00AF, "test move");
        if (n > 0 && n < 400) chk(32'(g), 32'(TC), "test rate");
        n++;
        g = 0;
        q = PHASE_IDX;
      end
    end
    chk(32'(n >= 400), 32'h0000_0001, "test half turns");
  endtask

  // Overall guard against a hang
  initial begin
    cyc(100000);
    hang("run too long");
  end

  // Main sequence
  initial begin
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, HSIZE} = '0;
    {NRST, EN_IN, req, dir} = 4'h0;
    exp_idx = IDX_RST;
    sws = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F};
    c = '0;
    cyc(20);
    NRST <= 1'b1;
    cyc(2);
    // Power-up state and register defaults
    chk(32'(PHASE_IDX), 32'h0000_0000, "start index");
    chk(32'(AMP_ON), 32'h0000_0001, "amp on");
    chk(32'(PHASE_CUR), 32'h0000_0008, "base current");
    rd(32'(OFS_CTRL), r);
    chk(r, CTRL_RST, "ctrl reset");
    rd(32'h0000_0010, r);
    chk(r, 32'h0000_0000, "unmapped read");
    rd(32'(OFS_CURRENT), r);
    chk(r, 32'h0000_0404, "current word");
    $display("test reset done");
    // Every switch weight alone, then all of them
    for (k = 0; k < 6; k++) begin
      c.cur = sws[k];
      wr(32'(OFS_CTRL), 32'(c));
      cyc(2);
      chk(32'(PHASE_CUR), 32'((int'(sws[k]) + 4) * 2), "phase current");
      rd(32'(OFS_CURRENT), r);
      chk(32'(r[5:0]), 32'(int'(sws[k]) + 4), "setpoint");
    end
    // A write to the read-only current word changes nothing
    wr(32'(OFS_CURRENT), 32'hFFFF_FFFF);
    rd(32'(OFS_CURRENT), r);
    chk(r, 32'h0000_2323, "current read-only");
    $display("test current done");
    // Each resolution: one step up, two down; the half-step pass crosses the table wrap
    c = '0;
    for (k = 0; k < 4; k++) begin
      c.res = stpdrv_res_e'(k);
      wr(32'(OFS_CTRL), 32'(c));
      stp(1'b1, res_step(k), 1'b1);
      chk(32'(PHASE_IDX), 32'(exp_idx), "index up");
      stp(1'b0, res_step(k), 1'b1);
      stp(1'b0, res_step(k), 1'b1);
      chk(32'(PHASE_IDX), 32'(exp_idx), "index down");
      rd(32'(OFS_STATUS), r);
      chk(r & 32'h0000_09FF, {23'h0, 1'b1, exp_idx}, "status");
    end
    $display("test resolution done");
    // Disabled outputs keep tracking steps
    EN_IN <= 1'b1;
    cyc(2);
    chk(32'(AMP_ON), 32'h0000_0000, "disabled");
    chk(32'(PHASE_CUR), 32'h0000_0000, "no current");
    stp(1'b1, INC_FIFTIETH, 1'b1);
    chk(32'(PHASE_IDX), 32'(exp_idx), "index while off");
    EN_IN <= 1'b0;
    cyc(2);
    chk(32'(AMP_ON), 32'h0000_0001, "re-enabled");
    chk(32'(PHASE_CUR), 32'h0000_0008, "current back");
    $display("test enable done");
    // Idle cut: not before the wait, then half, then cancelled by a step
    c = '0;
    c.idle = 1'b1;
    wr(32'(OFS_CTRL), 32'(c));
    stp(1'b1, INC_HALF, 1'b1);
    cyc(150);
    chk(32'(PHASE_CUR), 32'h0000_0008, "early idle");
    cyc(40);
    chk(32'(PHASE_CUR), 32'h0000_0004, "idle half");
    stp(1'b1, INC_HALF, 1'b1);
    chk(32'(PHASE_CUR), 32'h0000_0008, "idle cancel");
    chk(32'(PHASE_IDX), 32'(exp_idx), "index idle");
    wr(32'(OFS_CTRL), 32'h0000_0000);
    cyc(IT + 20);
    chk(32'(PHASE_CUR), 32'h0000_0008, "idle switch off");
    $display("test idle done");
    // Self test with fine resolution set and a step pulse arriving meanwhile
    c = '0;
    c.test = 1'b1;
    c.res = RES_FIFTIETH;
    wr(32'(OFS_CTRL), 32'(c));
    fork
      mon;
      stp(1'b0, INC_FIFTIETH, 1'b0);
    join
    EN_IN <= 1'b1;
    cyc(2);
    chk(32'(AMP_ON), 32'h0000_0000, "enable in test");
    chk(32'(PHASE_CUR), 32'h0000_0000, "no current in test");
    EN_IN <= 1'b0;
    wr(32'(OFS_CTRL), 32'h0000_0000);
    cyc(2);
    p = PHASE_IDX;
    cyc(20);
    chk(32'(PHASE_IDX), 32'(p), "test stopped");
    $display("test self test done");
    end_sim;
  end

  // Table advance per step, written out here for the expectations
  function automatic logic [7:0] res_step(input int k);
    case (k)
      0:       res_step = 8'h19;
      1:       res_step = 8'h0A;
      2:       res_step = 8'h05;
      default: res_step = 8'h01;
    endcase
  endfunction
endmodule // testbench

// File: stpdrv_tick.sv
`timescale 1ns/1ps
// Rate divider: one-cycle pulse every PERIOD cycles while enabled
module stpdrv_tick import stpdrv_pkg::*; #(
  parameter int unsigned PERIOD = TEST_STEP_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;  // Cycles since the last pulse
  } stpdrv_tick_s;

  stpdrv_tick_s st_r;
  stpdrv_tick_s st_nxt;

  // Count while running; restart from zero when stopped so each run starts with a full period
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = run && (st_r.cnt == LAST);

endmodule // stpdrv_tick

// File: stpdrv_top.sv
`timescale 1ns/1ps
module stpdrv_top import stpdrv_pkg::*; #(
  parameter int unsigned TEST_CYC = TEST_STEP_CYC,  // Cycles per self-test half step
  parameter int unsigned IDLE_WAIT = IDLE_CYC       // Still cycles before the idle cut
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        STEP_IN,
  input  wire logic        DIR_IN,
  input  wire logic        EN_IN,
  output logic [7:0]       PHASE_IDX,
  output logic [6:0]       PHASE_CUR,
  output logic             AMP_ON
);

  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_WAIT - 1);
  localparam logic [7:0]       HALF_LAST = HALF_REV_STEPS - 8'h01;

  // Whole state of the drive core
  typedef struct packed {
    logic             step_d;    // Step input one cycle ago
    logic [7:0]       idx;       // Phase table index
    logic             dir;       // Last direction moved
    stpdrv_tst_e      tst;       // Self-test phase
    logic [7:0]       tcnt;      // Half steps done in this test swing
    logic [CNT_W-1:0] idle_cnt;  // Cycles since the last step
    logic             idle_red;  // Current halved for idleness
    logic [6:0]       cur_out;   // Phase current, 0.05 A units
    logic             amp_on;    // Amplifiers enabled
  } stpdrv_core_s;

  stpdrv_core_s st_r;
  stpdrv_core_s st_nxt;
  stpdrv_ctrl_s ctrl;         // Switch image from software
  stpdrv_stat_s stat;         // Live state for software
  logic         test_tick;    // Self-test rate pulse
  logic         step_acc;     // Accepted external step edge
  logic         moved;        // Any step taken this cycle
  logic [5:0]   setpoint;     // Full current, 0.1 A units
  logic [6:0]   full_cur;     // Full current, 0.05 A units
  logic [13:0]  cur_word;     // Current readback word

  // Self-test rate divider; it only runs while the test pattern is active
  stpdrv_tick #(
    .PERIOD (TEST_CYC)
  ) u_tick (
    .clk   (MCLK),
    .rst_n (NRST),
    .run   (ctrl.test && (st_r.tst != TST_OFF)),
    .tick  (test_tick)
  );

  // Register access for the switch image and readback
  stpdrv_ahb u_ahb (
    .clk       (MCLK),
    .rst_n     (NRST),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .stat      (stat),
    .cur_word  (cur_word),
    .ctrl      (ctrl)
  );

  // Setpoint from the binary-weighted current switches
  assign setpoint = cur_set(ctrl.cur);
  assign full_cur = {setpoint, 1'b0};
  assign cur_word = {st_r.cur_out, 1'b0, setpoint};

  // Falling step edge; ignored while the test pattern owns the motor.
  // Inputs are treated as synchronous, so a 0.5 us pulse spans 25 cycles and is never missed.
  assign step_acc = st_r.step_d && !STEP_IN && !ctrl.test && (st_r.tst == TST_OFF);
  assign moved    = step_acc || test_tick;

  // Core next-state logic
  always_comb begin
    st_nxt        = st_r;
    st_nxt.step_d = STEP_IN;
    // Step tracking runs regardless of the enable input so position survives a disable
    if (step_acc) begin
      st_nxt.idx = idx_step(st_r.idx, res_inc(ctrl.res), DIR_IN);
      st_nxt.dir = DIR_IN;
    end
    // Self-test sequencer
    case (st_r.tst)
      TST_OFF: begin
        if (ctrl.test) begin
          st_nxt.tst  = TST_FWD;
          st_nxt.tcnt = 8'h00;
        end
      end
      TST_FWD, TST_REV: begin
        if (!ctrl.test) begin
          st_nxt.tst = TST_OFF;  // Stops where it stands when the switch returns
        end else if (test_tick) begin
          st_nxt.idx = idx_step(st_r.idx, INC_HALF, st_r.tst == TST_FWD);
          st_nxt.dir = (st_r.tst == TST_FWD);
          if (st_r.tcnt == HALF_LAST) begin
            st_nxt.tcnt = 8'h00;
            st_nxt.tst  = (st_r.tst == TST_FWD) ? TST_REV : TST_FWD;
          end else begin
            st_nxt.tcnt = st_r.tcnt + 8'h01;
          end
        end
      end
      default: begin
        st_nxt.tst = TST_OFF;
      end
    endcase
    // Idle timer: any motion restarts it and lifts the cut at once
    if (moved) begin
      st_nxt.idle_cnt = '0;
      st_nxt.idle_red = 1'b0;
    end else if (st_r.idle_cnt != IDLE_LAST) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
      st_nxt.idle_red = 1'b0;
    end else begin
      st_nxt.idle_red = ctrl.idle;
    end
    // Output stage; enable high wins in every mode, open input reads low and drives
    st_nxt.amp_on = !EN_IN;
    if (EN_IN) begin
      st_nxt.cur_out = CUR_OFF;
    end else if (st_nxt.idle_red) begin
      st_nxt.cur_out = {1'b0, setpoint};
    end else begin
      st_nxt.cur_out = full_cur;
    end
  end

  // State register; index comes up at table entry zero
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_r     <= '0;
      st_r.idx <= IDX_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat      = '{dir: st_r.dir, test_run: (st_r.tst != TST_OFF), idle_red: st_r.idle_red,
                       amp_on: st_r.amp_on, idx: st_r.idx};
  assign PHASE_IDX = st_r.idx;
  assign PHASE_CUR = st_r.cur_out;
  assign AMP_ON    = st_r.amp_on;

  // Checks on the core
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  en_cuts_cur_a: assert property (EN_IN |=> (PHASE_CUR == CUR_OFF) && !AMP_ON)
    else $error("current not removed while enable high");
  hold_track_a: assert property (EN_IN && step_acc |=> PHASE_IDX != $past(PHASE_IDX))
    else $error("step lost while disabled");
  open_en_a: assert property (!EN_IN |=> AMP_ON && (PHASE_CUR != CUR_OFF))
    else $error("current missing with enable low");
  full_cur_a: assert property (!EN_IN && !st_nxt.idle_red |=> PHASE_CUR == $past(full_cur))
    else $error("full current setpoint wrong");
  res_move_a: assert property (step_acc |=>
      PHASE_IDX == idx_step($past(PHASE_IDX), res_inc($past(ctrl.res)), $past(DIR_IN)))
    else $error("step increment wrong");
  idle_half_a: assert property (!EN_IN && st_nxt.idle_red |=>
      PHASE_CUR == {1'b0, $past(setpoint)})
    else $error("idle current not halved");
  idle_sw_a: assert property (!ctrl.idle |=> !st_r.idle_red)
    else $error("idle cut with switch off");
  test_half_a: assert property (test_tick |=>
      PHASE_IDX == idx_step($past(PHASE_IDX), INC_HALF, $past(st_r.tst) == TST_FWD))
    else $error("self test step wrong");
  test_turn_a: assert property (test_tick && ctrl.test && st_r.tst == TST_FWD && st_r.tcnt == HALF_LAST
      |=> st_r.tst == TST_REV)
    else $error("self test did not reverse");
  test_ignore_a: assert property (ctrl.test && $past(ctrl.test) && !test_tick |=> $stable(PHASE_IDX))
    else $error("step input moved motor in self test");
  idle_wait_a: assert property (st_r.idle_red |-> st_r.idle_cnt == IDLE_LAST)
    else $error("idle cut before wait elapsed");
  idle_cancel_a: assert property (moved |=> !st_r.idle_red && st_r.idle_cnt == '0)
    else $error("step did not cancel idle cut");

  idle_seen_c: cover property ($rose(st_r.idle_red));
  test_rev_c: cover property (st_r.tst == TST_FWD ##1 st_r.tst == TST_REV);
  step_dis_c: cover property (EN_IN && step_acc);
  wake_c: cover property (st_r.idle_red && step_acc);

endmodule // stpdrv_top
